/* rtl/fan_lut_entry_registers.sv */
// lut entries five and six with wishbone slave, mode control and duty selection
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ns
// Function
// - lut entry registers only take a written value while the lut write enable bit 5 is one.
// - in low resolution temperature mode bit 7 of each limit entry is held at zero.
// - in high resolution temperature mode bit 7 adds a half degree, compared on nine bits.
// - in low resolution temperature mode the limit is whole degrees, compared on eight bits.
// - a reading above the fifth limit but not above the sixth selects the fifth duty entry.
// - a reading above the sixth limit selects the sixth duty entry.
// - limits are unsigned, the sign bit is taken as zero and software writes no negatives.
// - the table temperature offset register is added to each limit to reach higher values.
// - in low resolution duty mode bits 7:6 of each duty entry are held at zero.
// - in high resolution duty mode bits 7:6 and 5:0 form the full eight-bit duty.
// - the extended duty bits only take effect while the 22.5 kHz pwm rate is selected.
// - in low resolution duty mode bits 5:0 of the fifth duty entry are its duty value.
module fan_lut_entry_registers
(
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_reset_n,
  input  wire fan_lut_pkg::wb_req_t       i_wb,
  input  wire fan_lut_pkg::temp_reading_t i_temp,
  input  wire logic                       i_conv_done,
  output logic                            o_wb_ack,
  output logic [31:0]                     o_wb_dat,
  output logic [7:0]                      o_pwm_duty,
  output logic                            o_duty_valid
);
  import fan_lut_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_reg;
  logic rst_n_sync;

  // release is synchronised so every flop on rst_n_sync leaves reset on the same edge
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_sync   <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_sync   <= rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic [7:0]  ctrl_reg;
  logic [7:0]  offset_reg;
  logic [7:0]  mode_reg;
  logic [7:0]  lim5_reg;
  logic [7:0]  duty5_reg;
  logic [7:0]  lim6_reg;
  logic [7:0]  duty6_reg;
  logic        ack_reg;
  logic [31:0] dat_reg;
  logic [7:0]  pwm_reg;
  logic        valid_reg;
  logic        exc5_reg;
  logic        exc6_reg;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire  [9:0] word_idx  = i_wb.adr[11:2];
  wire  [7:0] wdat      = i_wb.dat[7:0];
  wire        bus_req   = i_wb.cyc & i_wb.stb & ~ack_reg;
  // a write lands on the edge at which the master samples ack, never before it
  wire        wr_strobe = i_wb.cyc & i_wb.stb & ack_reg & i_wb.we & i_wb.sel[0];

  wire        hit_ctrl  = word_idx == IDX_LUT_CTRL;
  wire        hit_off   = word_idx == IDX_LUT_TEMP_OFFSET;
  wire        hit_mode  = word_idx == IDX_LUT_MODE;
  wire        hit_stat  = word_idx == IDX_LUT_STATUS;
  wire        hit_lim5  = word_idx == IDX_LIMIT_FIVE;
  wire        hit_duty5 = word_idx == IDX_DUTY_FIVE;
  wire        hit_lim6  = word_idx == IDX_LIMIT_SIX;
  wire        hit_duty6 = word_idx == IDX_DUTY_SIX;

  ////////////////////////////////////////////////////////////////////////////
  // mode decode
  wire lut_wr_en   = ctrl_reg[CTRL_LUT_WE_BIT];
  wire temp_hires  = mode_reg[MODE_TEMP_HIRES_BIT];
  wire duty_hires  = mode_reg[MODE_DUTY_HIRES_BIT];
  wire freq_22k5   = mode_reg[MODE_FREQ_22K5_BIT];
  // extended duty bits need both the mode and the 22.5 kHz rate
  wire duty_ext_on = duty_hires & freq_22k5;
  // entries are read-only unless the lut write enable is set
  wire wr_lut      = wr_strobe & lut_wr_en;

  ////////////////////////////////////////////////////////////////////////////
  // next values
  logic [7:0] ctrl_next;
  logic [7:0] offset_next;
  logic [7:0] mode_next;
  logic [7:0] lim5_next;
  logic [7:0] duty5_next;
  logic [7:0] lim6_next;
  logic [7:0] duty6_next;

  assign ctrl_next   = (wr_strobe & hit_ctrl) ? (wdat & 8'h20) : ctrl_reg;
  assign offset_next = (wr_strobe & hit_off) ? wdat : offset_reg;
  assign mode_next   = (wr_strobe & hit_mode) ? (wdat & 8'h07) : mode_reg;

  // masking runs every cycle, so a mode drop also clears bits already stored
  assign lim5_next  = limit_mask((wr_lut & hit_lim5) ? wdat : lim5_reg,
                                 temp_hires);
  assign lim6_next  = limit_mask((wr_lut & hit_lim6) ? wdat : lim6_reg,
                                 temp_hires);
  assign duty5_next = duty_mask((wr_lut & hit_duty5) ? wdat : duty5_reg,
                                duty_ext_on);
  assign duty6_next = duty_mask((wr_lut & hit_duty6) ? wdat : duty6_reg,
                                duty_ext_on);

  always_ff @(posedge i_sys_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      ctrl_reg   <= RST_LUT_CTRL;
      offset_reg <= RST_TEMP_OFFSET;
      mode_reg   <= RST_LUT_MODE;
      lim5_reg   <= RST_LIMIT;
      duty5_reg  <= RST_DUTY;
      lim6_reg   <= RST_LIMIT;
      duty6_reg  <= RST_DUTY;
    end
    else
    begin
      ctrl_reg   <= ctrl_next;
      offset_reg <= offset_next;
      mode_reg   <= mode_next;
      lim5_reg   <= lim5_next;
      duty5_reg  <= duty5_next;
      lim6_reg   <= lim6_next;
      duty6_reg  <= duty6_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path
  wire [31:0] status_word = {15'h0000, valid_reg, pwm_reg, 6'h00, exc6_reg, exc5_reg};
  wire [31:0] rd_data =
      hit_ctrl  ? {24'h000000, ctrl_reg}   :
      hit_off   ? {24'h000000, offset_reg} :
      hit_mode  ? {24'h000000, mode_reg}   :
      hit_stat  ? status_word              :
      hit_lim5  ? {24'h000000, lim5_reg}   :
      hit_duty5 ? {24'h000000, duty5_reg}  :
      hit_lim6  ? {24'h000000, lim6_reg}   :
      hit_duty6 ? {24'h000000, duty6_reg}  :
                  32'h00000000;

  // one wait state; unmapped words read zero and still get ack
  always_ff @(posedge i_sys_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end
    else
    begin
      ack_reg <= bus_req;
      dat_reg <= bus_req ? rd_data : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // limit comparison and duty selection
  logic exceed5;
  logic exceed6;

  fan_lut_limit_compare u_cmp_five
  (
    .i_hires    (temp_hires),
    .i_limit    (lim5_reg),
    .i_offset   (offset_reg),
    .i_temp     (i_temp),
    .o_exceeded (exceed5)
  );

  fan_lut_limit_compare u_cmp_six
  (
    .i_hires    (temp_hires),
    .i_limit    (lim6_reg),
    .i_offset   (offset_reg),
    .i_temp     (i_temp),
    .o_exceeded (exceed6)
  );

  // low resolution or no 22.5 kHz rate keeps bits 5:0 only, high resolution at 22.5 kHz the full byte
  wire [7:0] duty5_eff = duty_mask(duty5_reg, duty_ext_on);
  wire [7:0] duty6_eff = duty_mask(duty6_reg, duty_ext_on);

  // entry six outranks five; with neither exceeded the duty is zero
  wire [7:0] pwm_next =
      exceed6 ? duty6_eff :
      exceed5 ? duty5_eff :
                8'h00;

  // result held between conversions so the fan does not chase a moving reading
  always_ff @(posedge i_sys_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      pwm_reg   <= 8'h00;
      valid_reg <= 1'b0;
      exc5_reg  <= 1'b0;
      exc6_reg  <= 1'b0;
    end
    else if (i_conv_done)
    begin
      pwm_reg   <= pwm_next;
      valid_reg <= exceed5 | exceed6;
      exc5_reg  <= exceed5;
      exc6_reg  <= exceed6;
    end
  end

  assign o_wb_ack     = ack_reg;
  assign o_wb_dat     = dat_reg;
  assign o_pwm_duty   = pwm_reg;
  assign o_duty_valid = valid_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!rst_n_sync);

  a_lock_blocks_write: assert property (
    wr_strobe && hit_lim6 && !lut_wr_en |=> lim6_reg[6:0] == $past(lim6_reg[6:0]))
    else $error("limit six changed while lut writes locked");

  a_unlocked_write: assert property (
    wr_strobe && hit_duty6 && lut_wr_en && duty_ext_on |=> duty6_reg == $past(wdat))
    else $error("unlocked duty six write did not land");

  a_low_bit_seven: assert property (
    !temp_hires |=> !lim5_reg[7] && !lim6_reg[7])
    else $error("limit bit 7 set in low resolution mode");

  a_hires_limit: assert property (
    temp_hires && i_conv_done
    && ({1'b0, i_temp.deg, i_temp.half}
        > ({2'b00, lim6_reg[6:0], lim6_reg[7]} + {1'b0, offset_reg, 1'b0}))
    |=> o_duty_valid && o_pwm_duty == $past(duty6_eff))
    else $error("high resolution limit six not honoured");

  a_low_limit: assert property (
    !temp_hires && i_conv_done
    && ({1'b0, i_temp.deg} <= ({2'b00, lim5_reg[6:0]} + {1'b0, offset_reg}))
    && ({1'b0, i_temp.deg} <= ({2'b00, lim6_reg[6:0]} + {1'b0, offset_reg}))
    |=> !o_duty_valid ##1 !o_duty_valid || $past(i_conv_done))
    else $error("entry selected below both low resolution limits");

  a_select_five: assert property (
    i_conv_done && exceed5 && !exceed6
    |=> o_duty_valid && o_pwm_duty == $past(duty5_eff) && exc5_reg && !exc6_reg)
    else $error("fifth duty not selected");

  a_duty_low_bits: assert property (
    !duty_ext_on |=> duty5_reg[7:6] == 2'b00 && duty6_reg[7:6] == 2'b00)
    else $error("extended duty bits kept in low resolution");

  a_ext_needs_freq: assert property (
    !duty_ext_on && i_conv_done |=> o_pwm_duty[7:6] == 2'b00)
    else $error("extended duty used without 22.5 kHz");

  a_hold_between: assert property (
    !i_conv_done |=> $stable(o_pwm_duty) && $stable(o_duty_valid))
    else $error("duty changed without a conversion");

  a_ack_pulse: assert property (
    o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");

  a_ack_follows_req: assert property (
    i_wb.cyc && i_wb.stb && !o_wb_ack |=> o_wb_ack)
    else $error("request not answered after one wait state");

  a_dat_idle: assert property (
    !o_wb_ack |-> o_wb_dat == 32'h00000000)
    else $error("read data not zero outside ack");

  a_write_at_ack: assert property (
    wr_strobe |-> o_wb_ack)
    else $error("write taken while ack low");

  a_lock_duty_five: assert property (
    wr_strobe && hit_duty5 && !lut_wr_en |=> duty5_reg[5:0] == $past(duty5_reg[5:0]))
    else $error("duty five changed while lut writes locked");

  a_select_six_low: assert property (
    !temp_hires && i_conv_done
    && ({1'b0, i_temp.deg} > ({2'b00, lim6_reg[6:0]} + {1'b0, offset_reg}))
    |=> o_duty_valid && o_pwm_duty == $past(duty6_eff))
    else $error("low resolution limit six not honoured");

endmodule

/* rtl/fan_lut_pkg.sv */
// package: register indices, reset values, bit positions and carriers for the lut entry bank
package fan_lut_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices (byte address is four times the index)
  localparam logic [9:0] IDX_LUT_CTRL        = 10'h04A;
  localparam logic [9:0] IDX_LUT_TEMP_OFFSET = 10'h04E;
  localparam logic [9:0] IDX_LIMIT_FIVE      = 10'h058;
  localparam logic [9:0] IDX_DUTY_FIVE       = 10'h059;
  localparam logic [9:0] IDX_LIMIT_SIX       = 10'h05A;
  localparam logic [9:0] IDX_DUTY_SIX        = 10'h05B;
  localparam logic [9:0] IDX_LUT_MODE        = 10'h060;
  localparam logic [9:0] IDX_LUT_STATUS      = 10'h061;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RST_LIMIT       = 8'h7F;
  localparam logic [7:0] RST_DUTY        = 8'h3F;
  localparam logic [7:0] RST_TEMP_OFFSET = 8'h00;
  localparam logic [7:0] RST_LUT_CTRL    = 8'h00;
  localparam logic [7:0] RST_LUT_MODE    = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CTRL_LUT_WE_BIT     = 5;
  localparam int MODE_TEMP_HIRES_BIT = 0;
  localparam int MODE_DUTY_HIRES_BIT = 1;
  localparam int MODE_FREQ_22K5_BIT  = 2;
  localparam int LIMIT_HALF_BIT      = 7;
  localparam int DUTY_BASE_MSB       = 5;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic [7:0] deg;
    logic       half;
  } temp_reading_t;

  ////////////////////////////////////////////////////////////////////////////
  // masking shared by storage and selection
  function automatic logic [7:0] limit_mask(input logic [7:0] v, input logic hires);
    limit_mask = hires ? v : {1'b0, v[6:0]};
  endfunction

  function automatic logic [7:0] duty_mask(input logic [7:0] v, input logic ext_on);
    duty_mask = ext_on ? v : {2'b00, v[DUTY_BASE_MSB:0]};
  endfunction

endpackage

/* rtl/fan_lut_limit_compare.sv */
// one lut entry: offset-adjusted limit compared against the remote reading
`timescale 1ns/1ns
module fan_lut_limit_compare
(
  input  wire logic                       i_hires,
  input  wire logic [7:0]                 i_limit,
  input  wire logic [7:0]                 i_offset,
  input  wire fan_lut_pkg::temp_reading_t i_temp,
  output logic                            o_exceeded
);
  import fan_lut_pkg::*;

  logic [9:0] limit_half_units;
  logic [9:0] temp_half_units;
  logic [8:0] limit_deg;
  logic [8:0] temp_deg;
  logic       exc_hires;
  logic       exc_lores;

  // sign bit taken as zero: the entry is zero-extended, never sign-extended
  // offset widens the reach beyond the 7-bit field
  assign limit_half_units = {2'b00, i_limit[6:0], i_limit[LIMIT_HALF_BIT]}
                          + {1'b0, i_offset, 1'b0};
  assign temp_half_units  = {1'b0, i_temp.deg, i_temp.half};
  // high resolution: nine bits of the reading, half-degree step
  assign exc_hires        = temp_half_units > limit_half_units;

  assign limit_deg        = {2'b00, i_limit[6:0]} + {1'b0, i_offset};
  assign temp_deg         = {1'b0, i_temp.deg};
  // low resolution: eight bits of the reading, whole degrees
  assign exc_lores        = temp_deg > limit_deg;

  assign o_exceeded       = i_hires ? exc_hires : exc_lores;

endmodule

/* testbench/testbench.sv */
// self-checking bench for the lut entry bank: wishbone access and duty selection
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
  import fan_lut_pkg::*;

  localparam logic [11:0] A_CTRL = {IDX_LUT_CTRL, 2'b00};
  localparam logic [11:0] A_OFFS = {IDX_LUT_TEMP_OFFSET, 2'b00};
  localparam logic [11:0] A_LIM5 = {IDX_LIMIT_FIVE, 2'b00};
  localparam logic [11:0] A_DUT5 = {IDX_DUTY_FIVE, 2'b00};
  localparam logic [11:0] A_LIM6 = {IDX_LIMIT_SIX, 2'b00};
  localparam logic [11:0] A_DUT6 = {IDX_DUTY_SIX, 2'b00};
  localparam logic [11:0] A_MODE = {IDX_LUT_MODE, 2'b00};
  localparam logic [11:0] A_STAT = {IDX_LUT_STATUS, 2'b00};
  localparam logic [11:0] A_NONE = 12'h1F0;

  logic          i_sys_clk = 1'b0;
  logic          i_reset_n = 1'b0;
  wb_req_t       wb_req    = '0;
  temp_reading_t temp_in   = '0;
  logic          conv_done = 1'b0;
  logic          wb_ack;
  logic [31:0]   wb_dat;
  logic [7:0]    pwm_duty;
  logic          duty_valid;
  int            err_count = 0;
  int            cmp_count = 0;

  always #5 i_sys_clk = ~i_sys_clk;

  fan_lut_entry_registers i_fan_lut_entry_registers
  (
    .i_sys_clk    (i_sys_clk),
    .i_reset_n    (i_reset_n),
    .i_wb         (wb_req),
    .i_temp       (temp_in),
    .i_conv_done  (conv_done),
    .o_wb_ack     (wb_ack),
    .o_wb_dat     (wb_dat),
    .o_pwm_duty   (pwm_duty),
    .o_duty_valid (duty_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // one classic cycle; the request is held until ack is sampled high
  task automatic wb_cycle(input logic we, input logic [11:0] adr, input logic [31:0] d,
                          output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: d};
    @(posedge i_sys_clk);
    while (wb_ack !== 1'b1 && n < 20)
    begin
      @(posedge i_sys_clk);
      n++;
    end
    if (n >= 20)
    begin
      err_count++;
      $display("[ERR] t=%0t no ack for address %h", $time, adr);
    end
    q = wb_dat;
    wb_req <= '0;
  endtask

  task automatic wr(input logic [11:0] adr, input logic [7:0] d);
    logic [31:0] q;
    wb_cycle(1'b1, adr, {24'h000000, d}, q);
  endtask

  task automatic rd(input logic [11:0] adr, input logic [31:0] exp_v);
    logic [31:0] q;
    wb_cycle(1'b0, adr, 32'h00000000, q);
    `CHK(q, exp_v)
  endtask

  // present one conversion and check the selection one cycle after it is taken
  task automatic conv(input logic [7:0] deg, input logic h, input logic [7:0] exp_d,
                      input logic exp_v);
    @(posedge i_sys_clk);
    temp_in   <= '{deg: deg, half: h};
    conv_done <= 1'b1;
    @(posedge i_sys_clk);
    conv_done <= 1'b0;
    @(posedge i_sys_clk);
    `CHK(pwm_duty, exp_d)
    `CHK(duty_valid, exp_v)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_sys_clk);

    rd(A_LIM5, 32'h0000007F);
    rd(A_DUT5, 32'h0000003F);
    rd(A_LIM6, 32'h0000007F);
    rd(A_DUT6, 32'h0000003F);
    $display("test reset values done");

    // entries stay locked while the write enable bit is clear
    wr(A_LIM5, 8'h10);
    rd(A_LIM5, 32'h0000007F);
    wr(A_NONE, 8'h55);
    rd(A_NONE, 32'h00000000);
    wr(A_DUT5, 8'h01);
    rd(A_DUT5, 32'h0000003F);
    $display("test locked writes done");

    wr(A_CTRL, 8'h20);
    wr(A_LIM5, 8'hD0);
    rd(A_LIM5, 32'h00000050);
    wr(A_DUT5, 8'hE7);
    rd(A_DUT5, 32'h00000027);
    wr(A_LIM6, 8'h60);
    wr(A_DUT6, 8'h15);
    $display("test low resolution storage done");

    // low resolution: half degree ignored, strictly greater exceeds
    conv(8'h50, 1'b1, 8'h00, 1'b0);
    conv(8'h51, 1'b0, 8'h27, 1'b1);
    conv(8'h61, 1'b0, 8'h15, 1'b1);
    rd(A_STAT, 32'h00011503);
    $display("test low resolution selection done");

    wr(A_MODE, 8'h01);
    wr(A_LIM5, 8'hD0);
    rd(A_LIM5, 32'h000000D0);
    conv(8'h50, 1'b1, 8'h00, 1'b0);
    conv(8'h51, 1'b0, 8'h27, 1'b1);
    conv(8'h60, 1'b1, 8'h15, 1'b1);
    $display("test high resolution limit done");

    // leaving high resolution drops the half degree bit; offset lifts both limits
    wr(A_MODE, 8'h00);
    rd(A_LIM5, 32'h00000050);
    wr(A_OFFS, 8'h30);
    conv(8'h80, 1'b0, 8'h00, 1'b0);
    conv(8'h81, 1'b0, 8'h27, 1'b1);
    conv(8'h91, 1'b0, 8'h15, 1'b1);
    $display("test offset done");

    // extended duty bits need both duty high resolution and the 22.5 kHz rate
    wr(A_MODE, 8'h02);
    wr(A_DUT5, 8'hC5);
    rd(A_DUT5, 32'h00000005);
    wr(A_MODE, 8'h06);
    wr(A_DUT5, 8'hC5);
    rd(A_DUT5, 32'h000000C5);
    conv(8'h81, 1'b0, 8'hC5, 1'b1);
    wr(A_DUT6, 8'hD5);
    rd(A_DUT6, 32'h000000D5);
    conv(8'h91, 1'b0, 8'hD5, 1'b1);
    $display("test extended duty done");

    wr(A_CTRL, 8'h00);
    wr(A_LIM6, 8'h11);
    rd(A_LIM6, 32'h00000060);
    $display("test relock done");

    // reset in mid-run returns entries and the selected duty to their reset state
    i_reset_n <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    `CHK(pwm_duty, 8'h00)
    `CHK(duty_valid, 1'b0)
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    rd(A_LIM6, 32'h0000007F);
    rd(A_CTRL, 32'h00000000);
    $display("test mid-run reset done");
    wrap_up;
  end

  // the sequence needs well under a thousand cycles
  initial
  begin
    #200000;
    err_count++;
    wrap_up;
  end
endmodule
